//--- shared/poc_regs.svh
// register offsets, field positions and reset values of the payload octet counters
`ifndef POC_REGS_SVH
`define POC_REGS_SVH

//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// (RULE1) A 64-bit total adds the payload byte count of every qualifying received frame.
// (RULE2) A separate 64-bit total adds the payload byte count of every qualifying transmitted frame.
// (RULE3) Only frames free of FCS, oversize, undersize and payload length errors count or strobe.
// (RULE4) Each direction outputs a 16-bit payload byte count for the current frame.
// (RULE5) A per-direction strobe marks the count valid, and the client samples the count only then.
// (RULE6) Per-frame counts and strobes work even while the cumulative totals are switched off.
// (RULE7) Receive-side count and strobe are synchronous to the receive MAC clock; the code runs them on pclk.
// (RULE8) Transmit-side count and strobe are synchronous to the transmit MAC clock; the code runs them on pclk.
// (RULE9) The strobe is high for exactly one cycle per qualifying frame once its status is known.

//------------------------------------------------------------
// register map (byte addresses)
//------------------------------------------------------------
`define POC_ADDR_W        8
`define POC_CTRL_OFS      8'h00
`define POC_RX_LO_OFS     8'h04
`define POC_RX_HI_OFS     8'h08
`define POC_TX_LO_OFS     8'h0C
`define POC_TX_HI_OFS     8'h10

//------------------------------------------------------------
// control register fields
//------------------------------------------------------------
`define POC_CTRL_RX_EN    0
`define POC_CTRL_TX_EN    1
`define POC_CTRL_RX_CLR   2
`define POC_CTRL_TX_CLR   3
`define POC_CTRL_RESET    2'h3

//------------------------------------------------------------
// widths and constants
//------------------------------------------------------------
`define POC_TOTAL_W       64
`define POC_BYTES_W       16
`define POC_ZERO16        16'h0000
`define POC_ZERO32        32'h0000_0000
`define POC_ZERO64        64'h0000_0000_0000_0000

`endif

//--- shared/poc_pkg.sv
// types shared by the payload octet counter design
package poc_pkg;

  typedef enum logic [1:0]
  {
    POC_BUS_IDLE   = 2'b01,
    POC_BUS_ACCESS = 2'b10
  } poc_bus_state_t;

endpackage

//--- logic/poc_frame_qual.sv
// per-direction frame qualifier: per-frame byte count and one-cycle strobe
`timescale 1ns/1ps
`include "poc_regs.svh"

module poc_frame_qual
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     frame_end,
  input  wire logic [`POC_BYTES_W-1:0] frame_bytes,
  input  wire logic                     fcs_err,
  input  wire logic                     oversize_err,
  input  wire logic                     undersize_err,
  input  wire logic                     length_err,
  output logic      [`POC_BYTES_W-1:0] payload_bytes,
  output logic                          payload_strobe
);

  logic qualifies;

  //------------------------------------------------------------
  // qualification
  //------------------------------------------------------------
  // status is only trusted at the frame-end cycle
  assign qualifies = frame_end & ~(fcs_err | oversize_err | undersize_err | length_err); // RULE3

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // count holds between frames so a late sampler sees a stable value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      payload_bytes <= `POC_ZERO16;
    else if (qualifies)
      payload_bytes <= frame_bytes; // RULE4
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      payload_strobe <= 1'b0;
    else
      payload_strobe <= qualifies; // RULE9 RULE5
  end

endmodule

//--- logic/poc_top.sv
// payload octet counters: per-frame byte counts, 64-bit totals and apb register access
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "poc_regs.svh"

module poc_top
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`POC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     rx_frame_end,
  input  wire logic [`POC_BYTES_W-1:0] rx_frame_bytes,
  input  wire logic                     rx_fcs_err,
  input  wire logic                     rx_oversize_err,
  input  wire logic                     rx_undersize_err,
  input  wire logic                     rx_length_err,
  input  wire logic                     tx_frame_end,
  input  wire logic [`POC_BYTES_W-1:0] tx_frame_bytes,
  input  wire logic                     tx_fcs_err,
  input  wire logic                     tx_oversize_err,
  input  wire logic                     tx_undersize_err,
  input  wire logic                     tx_length_err,
  output logic      [`POC_BYTES_W-1:0] rx_frame_payload_bytes,
  output logic                          rx_frame_payload_strobe,
  output logic      [`POC_BYTES_W-1:0] tx_frame_payload_bytes,
  output logic                          tx_frame_payload_strobe
);

  poc_pkg::poc_bus_state_t        bus_state;
  logic [1:0]                     count_en;
  logic [`POC_TOTAL_W-1:0]        rx_good_payload_octet_total;
  logic [`POC_TOTAL_W-1:0]        tx_good_payload_octet_total;
  logic [31:0]                    hi_shadow;
  logic                           setup;
  logic                           wr_take;
  logic                           ctrl_wr;
  logic                           rx_clr;
  logic                           tx_clr;
  logic [31:0]                    next_prdata;
  logic                           next_pslverr;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic [`POC_TOTAL_W-1:0] accumulate
  (
    input logic [`POC_TOTAL_W-1:0] total,
    input logic                    add,
    input logic [`POC_BYTES_W-1:0] bytes
  );
    if (add)
      accumulate = total + {{(`POC_TOTAL_W-`POC_BYTES_W){1'b0}}, bytes};
    else
      accumulate = total;
  endfunction

  function automatic logic reg_hit
  (
    input logic [`POC_ADDR_W-1:0] addr
  );
    reg_hit = (addr == `POC_CTRL_OFS) || (addr == `POC_RX_LO_OFS) || (addr == `POC_RX_HI_OFS)
           || (addr == `POC_TX_LO_OFS) || (addr == `POC_TX_HI_OFS);
  endfunction

  //------------------------------------------------------------
  // per-direction qualifiers
  //------------------------------------------------------------
  // both run on pclk, which stands in for each MAC clock; they run regardless of count_en
  poc_frame_qual u_rx_qual
  (
    .clk            (pclk),
    .rst_n          (presetn),
    .frame_end      (rx_frame_end),
    .frame_bytes    (rx_frame_bytes),
    .fcs_err        (rx_fcs_err),
    .oversize_err   (rx_oversize_err),
    .undersize_err  (rx_undersize_err),
    .length_err     (rx_length_err),
    .payload_bytes  (rx_frame_payload_bytes),
    .payload_strobe (rx_frame_payload_strobe)
  ); // RULE7 RULE6

  poc_frame_qual u_tx_qual
  (
    .clk            (pclk),
    .rst_n          (presetn),
    .frame_end      (tx_frame_end),
    .frame_bytes    (tx_frame_bytes),
    .fcs_err        (tx_fcs_err),
    .oversize_err   (tx_oversize_err),
    .undersize_err  (tx_undersize_err),
    .length_err     (tx_length_err),
    .payload_bytes  (tx_frame_payload_bytes),
    .payload_strobe (tx_frame_payload_strobe)
  ); // RULE8 RULE6

  //------------------------------------------------------------
  // apb slave
  //------------------------------------------------------------
  assign setup   = psel & ~penable & (bus_state == poc_pkg::POC_BUS_IDLE);
  assign wr_take = psel & penable & pwrite & pready & (bus_state == poc_pkg::POC_BUS_ACCESS);
  assign ctrl_wr = wr_take & (paddr == `POC_CTRL_OFS) & pstrb[0];
  assign rx_clr  = ctrl_wr & pwdata[`POC_CTRL_RX_CLR];
  assign tx_clr  = ctrl_wr & pwdata[`POC_CTRL_TX_CLR];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_state <= poc_pkg::POC_BUS_IDLE;
    else
    begin
      unique case (bus_state)
        poc_pkg::POC_BUS_IDLE:
        begin
          if (setup)
            bus_state <= poc_pkg::POC_BUS_ACCESS;
        end
        poc_pkg::POC_BUS_ACCESS:
        begin
          bus_state <= poc_pkg::POC_BUS_IDLE;
        end
        default:
          bus_state <= poc_pkg::POC_BUS_IDLE;
      endcase
    end
  end

  // one wait-free access cycle; pready stays a flop so the bus sees no combinational path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // read data captured in the setup cycle; totals may move during the access cycle
  always_comb
  begin
    next_prdata  = `POC_ZERO32;
    next_pslverr = ~reg_hit(paddr);
    if (!pwrite)
    begin
      unique case (paddr)
        `POC_CTRL_OFS:  next_prdata = {30'h0000_0000, count_en};
        `POC_RX_LO_OFS: next_prdata = rx_good_payload_octet_total[31:0];
        `POC_RX_HI_OFS: next_prdata = hi_shadow;
        `POC_TX_LO_OFS: next_prdata = tx_good_payload_octet_total[31:0];
        `POC_TX_HI_OFS: next_prdata = hi_shadow;
        default:        next_prdata = `POC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `POC_ZERO32;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
    else
    begin
      prdata  <= `POC_ZERO32;
      pslverr <= 1'b0;
    end
  end

  // reading a low word freezes its high word, so a 64-bit read never tears across a carry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_shadow <= `POC_ZERO32;
    else if (setup && !pwrite && paddr == `POC_RX_LO_OFS)
      hi_shadow <= rx_good_payload_octet_total[63:32];
    else if (setup && !pwrite && paddr == `POC_TX_LO_OFS)
      hi_shadow <= tx_good_payload_octet_total[63:32];
  end

  //------------------------------------------------------------
  // control
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_en <= `POC_CTRL_RESET;
    else if (ctrl_wr)
      count_en <= {pwdata[`POC_CTRL_TX_EN], pwdata[`POC_CTRL_RX_EN]};
  end

  //------------------------------------------------------------
  // cumulative totals
  //------------------------------------------------------------
  // a clear and a frame in the same cycle: the frame survives as the new total
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_good_payload_octet_total <= `POC_ZERO64;
    else
      rx_good_payload_octet_total <= accumulate(rx_clr ? `POC_ZERO64 : rx_good_payload_octet_total,
                                                rx_frame_payload_strobe & count_en[`POC_CTRL_RX_EN],
                                                rx_frame_payload_bytes); // RULE1
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_good_payload_octet_total <= `POC_ZERO64;
    else
      tx_good_payload_octet_total <= accumulate(tx_clr ? `POC_ZERO64 : tx_good_payload_octet_total,
                                                tx_frame_payload_strobe & count_en[`POC_CTRL_TX_EN],
                                                tx_frame_payload_bytes); // RULE2
  end

endmodule

//--- dv/poc_client.sv
// client statistics model: sums per-frame counts under the strobe
`timescale 1ns/1ps
module poc_client
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stb,
  input  wire logic [15:0] bytes,
  output logic      [63:0] sum
);
  // ----
  // sampling
  // ----
  // count is only trusted while the strobe is high
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      sum <= 64'h0;
    else if (stb)
      sum <= sum + 64'(bytes);
endmodule

//--- dv/poc_top_asserts.sv
// port assertions for the payload octet counters
`timescale 1ns/1ps
`include "poc_regs.svh"
module poc_top_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rx_frame_end,
  input wire logic [15:0] rx_frame_bytes,
  input wire logic        rx_fcs_err,
  input wire logic        rx_oversize_err,
  input wire logic        rx_undersize_err,
  input wire logic        rx_length_err,
  input wire logic        tx_frame_end,
  input wire logic [15:0] tx_frame_bytes,
  input wire logic        tx_fcs_err,
  input wire logic        tx_oversize_err,
  input wire logic        tx_undersize_err,
  input wire logic        tx_length_err,
  input wire logic [15:0] rx_frame_payload_bytes,
  input wire logic        rx_frame_payload_strobe,
  input wire logic [15:0] tx_frame_payload_bytes,
  input wire logic        tx_frame_payload_strobe
);
  wire rx_ok = rx_frame_end & ~(rx_fcs_err | rx_oversize_err | rx_undersize_err | rx_length_err);
  wire tx_ok = tx_frame_end & ~(tx_fcs_err | tx_oversize_err | tx_undersize_err | tx_length_err);
  wire rs = rx_frame_payload_strobe;
  wire ts = tx_frame_payload_strobe;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // per-frame count and strobe
  // ----
  property p_rx_ok; rx_ok |=> rs && rx_frame_payload_bytes == $past(rx_frame_bytes); endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("rx count or strobe wrong");
  property p_tx_ok; tx_ok |=> ts && tx_frame_payload_bytes == $past(tx_frame_bytes); endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("tx count or strobe wrong");
  property p_rx_one; rs |-> $past(rx_ok); endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx strobe without frame");
  property p_tx_bad; !tx_ok |=> !ts; endproperty
  a_tx_bad: assert property (p_tx_bad) else $error("tx strobe on bad frame");
  property p_rx_hold; !rx_ok |=> $stable(rx_frame_payload_bytes); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx count moved");
  property p_tx_hold; !tx_ok |=> $stable(tx_frame_payload_bytes); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx count moved");
  property p_rx_run; rx_ok ##1 rx_ok |-> rs ##1 rs; endproperty
  a_rx_run: assert property (p_rx_run) else $error("rx back to back lost");
  property p_both; rx_ok && tx_ok |=> rs && ts; endproperty
  a_both: assert property (p_both) else $error("direction strobes lost");
  // ----
  // register access path to the totals
  // ----
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer late");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("apb answer too long");
  property p_idle_data; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle_data: assert property (p_idle_data) else $error("apb data outside answer");
  c_rx_run: cover property (rx_ok ##1 rx_ok);
  c_both: cover property (rx_ok && tx_ok);
  c_bad: cover property (rx_frame_end && rx_fcs_err);
endmodule
bind poc_top poc_top_asserts u_poc_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_frame_end(rx_frame_end),
  .rx_frame_bytes(rx_frame_bytes), .rx_fcs_err(rx_fcs_err), .rx_oversize_err(rx_oversize_err),
  .rx_undersize_err(rx_undersize_err), .rx_length_err(rx_length_err), .tx_frame_end(tx_frame_end),
  .tx_frame_bytes(tx_frame_bytes), .tx_fcs_err(tx_fcs_err), .tx_oversize_err(tx_oversize_err),
  .tx_undersize_err(tx_undersize_err), .tx_length_err(tx_length_err), .tx_frame_payload_strobe(tx_frame_payload_strobe),
  .rx_frame_payload_bytes(rx_frame_payload_bytes), .rx_frame_payload_strobe(rx_frame_payload_strobe),
  .tx_frame_payload_bytes(tx_frame_payload_bytes));

//--- dv/tb.sv
// self-checking bench for the payload octet counters
`timescale 1ns/1ps
`include "poc_regs.svh"
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h0001_4D35;
  logic        fe[2], fc[2], ov[2], un[2], ln[2], stb[2], e_stb[2];
  logic [15:0] fb[2], pb[2], e_pb[2];
  logic [63:0] sum[2], tot[2], psum[2], rd;
  logic [1:0]  en;
  int          fails = 0, num_checks = 0;
  always #4 pclk = ~pclk;
  poc_top u_poc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_end(fe[0]), .rx_frame_bytes(fb[0]), .rx_fcs_err(fc[0]), .rx_oversize_err(ov[0]),
    .rx_undersize_err(un[0]), .rx_length_err(ln[0]), .tx_frame_end(fe[1]), .tx_frame_bytes(fb[1]),
    .tx_fcs_err(fc[1]), .tx_oversize_err(ov[1]), .tx_undersize_err(un[1]), .tx_length_err(ln[1]),
    .rx_frame_payload_bytes(pb[0]), .rx_frame_payload_strobe(stb[0]),
    .tx_frame_payload_bytes(pb[1]), .tx_frame_payload_strobe(stb[1]));
  poc_client u_client_rx (.clk(pclk), .rst_n(presetn), .stb(stb[0]), .bytes(pb[0]), .sum(sum[0]));
  poc_client u_client_tx (.clk(pclk), .rst_n(presetn), .stb(stb[1]), .bytes(pb[1]), .sum(sum[1]));
  // ----
  // reference model and per-cycle compare
  // ----
  always @(posedge pclk or negedge presetn)
    for (int d = 0; d < 2; d++)
    begin
      if (!presetn)
      begin
        e_stb[d] = 1'b0; e_pb[d] = 16'h0; tot[d] = 64'h0; psum[d] = 64'h0; en = 2'h3;
      end
      else
      begin
        if (e_stb[d] && en[d]) tot[d] += e_pb[d];
        if (e_stb[d]) psum[d] += e_pb[d];
        e_stb[d] = fe[d] && !(fc[d] || ov[d] || un[d] || ln[d]);
        if (e_stb[d]) e_pb[d] = fb[d];
      end
    end
  always @(negedge pclk)
    if (presetn)
      for (int d = 0; d < 2; d++)
      begin
        chk(stb[d], e_stb[d]);
        chk(pb[d], e_pb[d]);
      end
  // ----
  // tasks
  // ----
  function logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [63:0] s, input logic [63:0] x);
    num_checks++;
    if (s !== x)
    begin
      fails++;
      $display("[ERR] %0t seen %0h exp %0h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 50);
    if (!pready) fails++;
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (w && a == `POC_CTRL_OFS)
    begin
      en = d[1:0];
      if (d[2]) tot[0] = 64'h0;
      if (d[3]) tot[1] = 64'h0;
    end
  endtask
  task tots();
    for (int d = 0; d < 2; d++)
    begin
      apb(0, d ? `POC_TX_LO_OFS : `POC_RX_LO_OFS, 0); rd[31:0] = q;
      apb(0, d ? `POC_TX_HI_OFS : `POC_RX_HI_OFS, 0); rd[63:32] = q;
      chk(rd, tot[d]);
    end
  endtask
  task frames(input int n, input logic bad);
    repeat (n)
    begin
      @(posedge pclk);
      for (int d = 0; d < 2; d++)
      begin
        q = rnd();
        fe[d] <= q[0] | q[1]; fb[d] <= q[31:16];
        fc[d] <= bad && !q[3:2]; ov[d] <= bad && !q[5:4]; un[d] <= bad && !q[7:6]; ln[d] <= bad && !q[9:8];
      end
    end
    @(posedge pclk);
    for (int d = 0; d < 2; d++) fe[d] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial
  begin
    for (int d = 0; d < 2; d++)
    begin
      fe[d] = 0; fb[d] = 0; fc[d] = 0; ov[d] = 0; un[d] = 0; ln[d] = 0;
    end
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `POC_CTRL_OFS, 0); chk(q, `POC_CTRL_RESET);
    apb(1, `POC_RX_LO_OFS, 32'hFFFF_FFFF); tots();
    apb(0, 8'h14, 0); chk({e, q}, {1'b1, 32'h0});
    $display("test registers done");
    frames(80, 1'b0); tots();
    frames(120, 1'b1); tots();
    $display("test frames done");
    apb(1, `POC_CTRL_OFS, 32'h0); frames(40, 1'b0); tots();
    apb(1, `POC_CTRL_OFS, 32'hF); tots();
    for (int d = 0; d < 2; d++) chk(sum[d], psum[d]);
    $display("test control done");
    end_sim();
  end
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
